// File: logic/slf_pkg.sv
// Shared constants, enumerations and carrier types of the frame-end and link-status register bank
package slf_pkg;

  // ****************************************************************
  // Register indices and bus geometry
  // ****************************************************************
  localparam int              SLF_ADDR_W        = 16;       // APB byte address width
  localparam logic [13:0]     SLF_IDX_EOF_SEL   = 14'h0207; // frame_end_char_select index
  localparam logic [13:0]     SLF_IDX_STATUS    = 14'h0208; // link_status_flags index
  localparam logic [13:0]     SLF_IDX_LINK_CTRL = 14'h020A; // Link control index

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0]      SLF_EOF_SEL_RST   = 8'h00;    // Frame-end select after reset
  localparam logic [7:0]      SLF_LINK_CTRL_RST = 8'h00;    // Link control after reset
  localparam logic            SLF_FLAG_RST      = 1'b0;     // Sticky flags after reset

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int              SLF_ST_LINK_UP    = 6;        // Link operational
  localparam int              SLF_ST_SYNC       = 5;        // Sync line level
  localparam int              SLF_ST_REALIGN    = 4;        // Phase realigned, sticky
  localparam int              SLF_ST_MULTIFRAME_PHASE_SET_FLAG    = 3;        // Multiframe phase set, sticky
  localparam int              SLF_ST_SPLL       = 2;        // Serial PLL lock
  localparam int              SLF_ST_CPLL       = 0;        // Converter PLL lock
  localparam int              SLF_CT_ENABLE     = 0;        // serial_link_enable bit
  localparam int              SLF_CT_SRC_LO     = 2;        // Sync source select, low bit
  localparam int              SLF_CT_SW_SYNC    = 4;        // Software sync level

  // ****************************************************************
  // Comma characters as 8b/10b control octets
  // ****************************************************************
  localparam logic [7:0]      SLF_K28_7         = 8'hFC;    // K28.7
  localparam logic [7:0]      SLF_K28_1         = 8'h3C;    // K28.1
  localparam logic [7:0]      SLF_K28_5         = 8'hBC;    // K28.5

  // ****************************************************************
  // Enumerations
  // ****************************************************************
  // Frame-end comma selection codes
  typedef enum logic [1:0] {
    SLF_EOF_K28_7 = 2'h0,
    SLF_EOF_K28_1 = 2'h1,
    SLF_EOF_K28_5 = 2'h2,
    SLF_EOF_RSVD  = 2'h3
  } slf_eof_sel_type;

  // Sync line source codes
  typedef enum logic [1:0] {
    SLF_SRC_PIN   = 2'h0,
    SLF_SRC_TMSTP = 2'h1,
    SLF_SRC_SOFT  = 2'h2,
    SLF_SRC_RSVD  = 2'h3
  } slf_sync_src_type;

  // Multiframe alignment tracker, one-hot
  typedef enum logic [2:0] {
    SLF_AL_IDLE  = 3'b001,
    SLF_AL_ARMED = 3'b010,
    SLF_AL_DONE  = 3'b100
  } slf_align_state_type;

  // ****************************************************************
  // Carrier types
  // ****************************************************************
  // Octet offered to the transmitter at the frame-end position
  typedef struct packed {
    logic [7:0] data;       // Payload octet
    logic       frameEnd;   // Last octet of a frame
    logic       replaceOk;  // Frame content allows replacement
  } slf_tx_in_type;

  // Octet handed on to the encoder
  typedef struct packed {
    logic [7:0] data;       // Octet value
    logic       isK;        // Control character flag
  } slf_tx_out_type;

  // Events and levels from the link core, same clock
  typedef struct packed {
    logic linkUp;           // Link operational level
    logic sysrefEvent;      // One-cycle SYSREF capture pulse
    logic realignEvent;     // One-cycle clock phase realignment pulse
  } slf_core_in_type;

endpackage : slf_pkg

// File: logic/slf_eof_inserter.sv
// Opportunistic frame-end comma replacement in the transmit octet path
`timescale 1ns/10ps
module slf_eof_inserter
  import slf_pkg::*;
(
  input  wire logic           clk,
  input  wire logic           nrst,
  input  wire slf_tx_in_type  txIn,
  input  wire logic [1:0]     eofSel,
  input  wire logic           mode8b10b,
  input  wire logic           linkEnable,
  output slf_tx_out_type      txOut
);

  // ****************************************************************
  // Comma lookup
  // ****************************************************************
  logic [7:0]     commaCode;    // Comma for the current selection
  logic           commaValid;   // Selection names a real comma
  logic           doReplace;    // Replace this octet

  // Map the select code onto the comma octet
  always_comb begin
    commaCode  = SLF_K28_7;
    commaValid = 1'b1;
    case (slf_eof_sel_type'(eofSel))
      SLF_EOF_K28_7: commaCode = SLF_K28_7;
      SLF_EOF_K28_1: commaCode = SLF_K28_1;
      SLF_EOF_K28_5: commaCode = SLF_K28_5;
      default: begin
        // Reserved code inserts nothing
        commaValid = 1'b0;
      end
    endcase
  end

  // Only frame ends whose content allows it, and only in 8b/10b
  assign doReplace = linkEnable & mode8b10b & txIn.frameEnd & txIn.replaceOk & commaValid;

  // ****************************************************************
  // Output register
  // ****************************************************************
  // Pass the octet or substitute the comma
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      txOut <= '0;
    end else if (doReplace) begin
      txOut.data <= commaCode;
      txOut.isK  <= 1'b1;
    end else begin
      txOut.data <= txIn.data;
      txOut.isK  <= 1'b0;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_k28_7_pick: assert property (@(posedge clk) disable iff (!nrst)
    (doReplace && eofSel == 2'h0) |=> (txOut.isK && txOut.data == 8'hFC))
    else $error("frame end comma is not K28.7");

  a_no_blind_insert: assert property (@(posedge clk) disable iff (!nrst)
    (txIn.frameEnd && !txIn.replaceOk) |=> (txOut.data == $past(txIn.data) && !txOut.isK))
    else $error("comma replaced a frame end that did not allow it");

  a_none_in_66b: assert property (@(posedge clk) disable iff (!nrst)
    !mode8b10b |=> !txOut.isK)
    else $error("comma inserted in a 64b/66b mode");

endmodule : slf_eof_inserter

// File: logic/slf_link_status_regs.sv
// APB register bank for frame-end comma selection and serial link status
//
// Function
// - Two-bit select picks K28.7, K28.1, K28.5.
// - Comma replaces frame end only when allowed.
// - Selection applies only to 8b/10b modes.
// - Bit 6 shows link up.
// - Bit 5 shows sync line level.
// - Bit 4 sticky realign flag, write-one clears.
// - Bit 3 set by first SYSREF after enable.
// - Bit 2 shows serial PLL lock.
// - Bit 0 shows converter PLL lock.
// - Sync line from pin, timestamp or software.
//
// The APB slave port is this design's own decision.
`timescale 1ns/10ps
module slf_link_status_regs
  import slf_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  nrst,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [SLF_ADDR_W-1:0] paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire slf_core_in_type       coreIn,
  input  wire logic                  syncPinN,
  input  wire logic                  tmstpPinN,
  input  wire logic                  serialPllLockRaw,
  input  wire logic                  converterPllLockRaw,
  input  wire logic                  mode8b10b,
  input  wire slf_tx_in_type         txIn,
  output slf_tx_out_type             txOut,
  output logic                       serialLinkEnable,
  output logic                       syncReqN
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [3:0] pinRaw;     // Asynchronous inputs
  logic [3:0] pinMeta;    // First stage, read only by second stage
  logic [3:0] pinSync;    // Second stage, safe to use
  logic       syncPinS;   // Synchronised sync pin
  logic       tmstpPinS;  // Synchronised timestamp pin
  logic       spllLock;   // Synchronised serial PLL lock
  logic       cpllLock;   // Synchronised converter PLL lock

  assign pinRaw = {converterPllLockRaw, serialPllLockRaw, tmstpPinN, syncPinN};

  // Two flip-flops per asynchronous input
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sync
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          pinMeta[gi] <= 1'b0;
          pinSync[gi] <= 1'b0;
        end else begin
          pinMeta[gi] <= pinRaw[gi];
          pinSync[gi] <= pinMeta[gi];
        end
      end
    end
  endgenerate

  assign syncPinS  = pinSync[0];
  assign tmstpPinS = pinSync[1];
  assign spllLock  = pinSync[2];
  assign cpllLock  = pinSync[3];

  // ****************************************************************
  // APB decode
  // ****************************************************************
  logic       hitSel;     // Address names the frame-end select
  logic       hitStatus;  // Address names the status register
  logic       hitCtrl;    // Address names link control
  logic       hitAny;     // Any mapped register
  logic       accessWr;   // Write completes this edge
  logic       setupRd;    // Read setup phase
  logic       wrSel;      // Write to frame-end select
  logic       wrStatus;   // Write to status
  logic       wrCtrl;     // Write to link control

  assign hitSel    = (paddr == {SLF_IDX_EOF_SEL, 2'b00});
  assign hitStatus = (paddr == {SLF_IDX_STATUS, 2'b00});
  assign hitCtrl   = (paddr == {SLF_IDX_LINK_CTRL, 2'b00});
  assign hitAny    = hitSel | hitStatus | hitCtrl;
  assign accessWr  = psel & penable & pwrite;
  assign setupRd   = psel & ~penable & ~pwrite;
  assign wrSel     = accessWr & hitSel;
  assign wrStatus  = accessWr & hitStatus;
  assign wrCtrl    = accessWr & hitCtrl;

  // Zero-wait slave; unmapped addresses answer with an error
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hitAny;

  // ****************************************************************
  // Writable registers
  // ****************************************************************
  logic [7:0] eofSelReg;  // frame_end_char_select, all bits stored
  logic [7:0] linkCtrl;   // Enable, sync source, software sync

  // Frame-end select register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      eofSelReg <= SLF_EOF_SEL_RST;
    end else if (wrSel) begin
      eofSelReg <= pwdata[7:0];
    end
  end

  // Link control register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      linkCtrl <= SLF_LINK_CTRL_RST;
    end else if (wrCtrl) begin
      linkCtrl <= pwdata[7:0];
    end
  end

  assign serialLinkEnable = linkCtrl[SLF_CT_ENABLE];

  // ****************************************************************
  // Sync line selection
  // ****************************************************************
  logic [1:0] syncSrc;    // Selected source code

  assign syncSrc = linkCtrl[SLF_CT_SRC_LO +: 2];

  // Route the chosen source onto the sync line
  always_comb begin
    case (slf_sync_src_type'(syncSrc))
      SLF_SRC_PIN:   syncReqN = syncPinS;
      SLF_SRC_TMSTP: syncReqN = tmstpPinS;
      SLF_SRC_SOFT:  syncReqN = linkCtrl[SLF_CT_SW_SYNC];
      default: begin
        // Reserved code falls back to the dedicated pin
        syncReqN = syncPinS;
      end
    endcase
  end

  // ****************************************************************
  // Multiframe alignment tracker
  // ****************************************************************
  slf_align_state_type alignState;      // Tracker state
  slf_align_state_type next_alignState; // Next tracker state
  logic                enableDly;       // Enable, one cycle late
  logic                enableRise;      // Enable just set

  assign enableRise = serialLinkEnable & ~enableDly;

  // Remember the enable to find its rising edge
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      enableDly <= 1'b0;
    end else begin
      enableDly <= serialLinkEnable;
    end
  end

  // Arm on enable, finish on the first SYSREF after it
  always_comb begin
    next_alignState = alignState;
    case (alignState)
      SLF_AL_IDLE: begin
        if (enableRise) begin
          next_alignState = SLF_AL_ARMED;
        end
      end
      SLF_AL_ARMED: begin
        if (!serialLinkEnable) begin
          next_alignState = SLF_AL_IDLE;
        end else if (coreIn.sysrefEvent) begin
          next_alignState = SLF_AL_DONE;
        end
      end
      SLF_AL_DONE: begin
        if (!serialLinkEnable) begin
          next_alignState = SLF_AL_IDLE;
        end
      end
      default: begin
        next_alignState = SLF_AL_IDLE;
      end
    endcase
  end

  // Tracker state register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      alignState <= SLF_AL_IDLE;
    end else begin
      alignState <= next_alignState;
    end
  end

  // ****************************************************************
  // Sticky flags
  // ****************************************************************
  logic alignSet;      // Multiframe phase established this cycle
  logic realignFlag;   // Phase realigned flag
  logic alignedFlag;   // multiframe_phase_set_flag

  assign alignSet = (alignState == SLF_AL_ARMED) & serialLinkEnable & coreIn.sysrefEvent;

  // Realign flag: a new event wins over a write-one clear
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      realignFlag <= SLF_FLAG_RST;
    end else if (coreIn.realignEvent) begin
      realignFlag <= 1'b1;
    end else if (wrStatus && pwdata[SLF_ST_REALIGN]) begin
      realignFlag <= 1'b0;
    end
  end

  // Multiframe_phase_set_flag flag: set wins over clear as well
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      alignedFlag <= SLF_FLAG_RST;
    end else if (alignSet) begin
      alignedFlag <= 1'b1;
    end else if (wrStatus && pwdata[SLF_ST_MULTIFRAME_PHASE_SET_FLAG]) begin
      alignedFlag <= 1'b0;
    end
  end

  // ****************************************************************
  // Status word and read data
  // ****************************************************************
  logic [7:0] statusWord;  // Live view of link_status_flags

  // Live bits come from hardware, never from status writes; bit 5 follows linkCtrl[4] under software sync
  always_comb begin
    statusWord                 = 8'h00;
    statusWord[SLF_ST_LINK_UP] = coreIn.linkUp;
    statusWord[SLF_ST_SYNC]    = syncReqN;
    statusWord[SLF_ST_REALIGN] = realignFlag;
    statusWord[SLF_ST_MULTIFRAME_PHASE_SET_FLAG] = alignedFlag;
    statusWord[SLF_ST_SPLL]    = spllLock;
    statusWord[SLF_ST_CPLL]    = cpllLock;
  end

  // Capture read data during the setup phase
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prdata <= 32'h0000_0000;
    end else if (setupRd) begin
      if (hitSel) begin
        prdata <= {24'h00_0000, eofSelReg};
      end else if (hitStatus) begin
        prdata <= {24'h00_0000, statusWord};
      end else if (hitCtrl) begin
        prdata <= {24'h00_0000, linkCtrl};
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // ****************************************************************
  // Frame-end comma path
  // ****************************************************************
  slf_eof_inserter u_eof (
    .clk        (clk),
    .nrst       (nrst),
    .txIn       (txIn),
    .eofSel     (eofSelReg[1:0]),
    .mode8b10b  (mode8b10b),
    .linkEnable (serialLinkEnable),
    .txOut      (txOut)
  );

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_link_up_live: assert property (@(posedge clk) disable iff (!nrst)
    statusWord[6] == coreIn.linkUp)
    else $error("link up bit does not follow the link");

  a_sync_bit_pin: assert property (@(posedge clk) disable iff (!nrst)
    (syncSrc == 2'h0) |-> (statusWord[5] == $past(syncPinN, 2)))
    else $error("sync status does not follow the sync pin");

  a_realign_set: assert property (@(posedge clk) disable iff (!nrst)
    coreIn.realignEvent |=> statusWord[4])
    else $error("realign event did not set its flag");

  a_realign_clear: assert property (@(posedge clk) disable iff (!nrst)
    (wrStatus && pwdata[4] && !coreIn.realignEvent) |=> !realignFlag)
    else $error("write of one did not clear realign flag");

  a_multiframe_phase_set_flag_first: assert property (@(posedge clk) disable iff (!nrst)
    (enableRise ##1 (serialLinkEnable && coreIn.sysrefEvent)) |=>
      (alignedFlag && alignState == SLF_AL_DONE))
    else $error("first SYSREF after enable did not set multiframe_phase_set_flag flag");

  a_multiframe_phase_set_flag_hold: assert property (@(posedge clk) disable iff (!nrst)
    (alignedFlag && !(wrStatus && pwdata[3])) |=> alignedFlag)
    else $error("multiframe_phase_set_flag flag dropped without a clear");

  a_spll_lock: assert property (@(posedge clk) disable iff (!nrst)
    statusWord[2] == $past(serialPllLockRaw, 2))
    else $error("serial PLL lock bit wrong");

  a_cpll_lock: assert property (@(posedge clk) disable iff (!nrst)
    statusWord[0] == $past(converterPllLockRaw, 2))
    else $error("converter PLL lock bit wrong");

  a_soft_sync: assert property (@(posedge clk) disable iff (!nrst)
    (syncSrc == 2'h2) |-> (syncReqN == linkCtrl[4]))
    else $error("software sync not routed to sync line");

  a_live_ignore: assert property (@(posedge clk) disable iff (!nrst)
    (wrStatus && pwdata[6] && !coreIn.linkUp) ##1 !coreIn.linkUp |-> !statusWord[6])
    else $error("write changed the link up bit");

endmodule : slf_link_status_regs

// File: verification/slf_rx_partner.sv
// Receiver-side model that drives the active-low sync request pin
`timescale 1ns/10ps
module slf_rx_partner (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       reqSync,
  input  wire logic [3:0] lag,
  output logic            syncPinN
);
  logic [3:0] hold; // Cycles left before the request is lifted

  // ****************************************************************
  // Request stays low while asked for, then for lag more cycles
  // ****************************************************************
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hold     <= 4'h0;
      syncPinN <= 1'b0;
    end else if (reqSync) begin // Receiver not yet in sync
      hold     <= lag;
      syncPinN <= 1'b0;
    end else if (hold != 4'h0) begin // Slow release
      hold <= hold - 4'h1;
    end else begin
      syncPinN <= 1'b1;
    end
  end
endmodule : slf_rx_partner

// File: verification/test_serial_link_frame_char_and_status.sv
// Self-checking bench of the frame-end select and link status registers
`timescale 1ns/10ps
`define CHK(a, b) check(32'(a), 32'(b))
module test_serial_link_frame_char_and_status;
  import slf_pkg::*;
  logic            clk, nrst, psel, penable, pwrite, pready, pslverr;
  logic [15:0]     paddr;
  logic [31:0]     pwdata, prdata, rv;
  slf_core_in_type coreIn;
  logic            syncPinN, tmstpPinN, spll, cpll, mode8b10b, linkEnable, syncReqN;
  logic            reqSync, ev;
  logic [3:0]      lag;
  slf_tx_in_type   txIn;
  slf_tx_out_type  txOut, expTx;
  logic [31:0]     lfsr, ctrl;          // Random state, model of link control
  logic            rl, al;              // Model sticky flags
  int              failures, checked;
  localparam logic [15:0] A_EOF  = {SLF_IDX_EOF_SEL, 2'b00};
  localparam logic [15:0] A_STAT = {SLF_IDX_STATUS, 2'b00};
  localparam logic [15:0] A_CTRL = {SLF_IDX_LINK_CTRL, 2'b00};

  slf_link_status_regs slf_link_status_regs_inst (.clk(clk), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .coreIn(coreIn), .syncPinN(syncPinN),
    .tmstpPinN(tmstpPinN), .serialPllLockRaw(spll), .converterPllLockRaw(cpll),
    .mode8b10b(mode8b10b), .txIn(txIn), .txOut(txOut), .serialLinkEnable(linkEnable),
    .syncReqN(syncReqN));
  slf_rx_partner slf_rx_partner_inst (.clk(clk), .nrst(nrst), .reqSync(reqSync),
    .lag(lag), .syncPinN(syncPinN));

  // ****************************************************************
  // Clock and watchdog
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    report_and_stop();
  end

  // ****************************************************************
  // Helpers: compare, random, verdict, bus cycles
  // ****************************************************************
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction : rnd
  task automatic report_and_stop();
    if (failures == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : report_and_stop
  // One APB transfer, held until pready is seen high
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rv, ev);
    `CHK(ev, 1'b0);
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, rv, ev);
    `CHK(rv, exp);
  endtask : rd
  // Model of the status word from the bench's own record
  function automatic logic [31:0] stat();
    logic s;
    case (ctrl[3:2])
      2'h1:    s = tmstpPinN;
      2'h2:    s = ctrl[4];
      default: s = ~reqSync;
    endcase
    return {25'h0, coreIn.linkUp, s, rl, al, spll, 1'b0, cpll};
  endfunction : stat
  task automatic pulse(input logic sys);
    if (sys) coreIn.sysrefEvent <= 1'b1;
    else coreIn.realignEvent <= 1'b1;
    @(posedge clk);
    coreIn <= {coreIn.linkUp, 2'b00};
    @(posedge clk);
  endtask : pulse

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    {nrst, psel, penable, pwrite, paddr, pwdata, coreIn, spll, cpll, txIn} = '0;
    {tmstpPinN, mode8b10b, reqSync, lag, rl, al, ctrl} = {3'b110, 4'h3, 34'h0};
    {failures, checked, lfsr} = {32'h0, 32'h0, 32'hAF4EE641};
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    repeat (6) @(posedge clk);
    rd(A_EOF, 32'h0);
    rd(A_STAT, stat());
    apb(1'b1, 16'h0830, 32'hFF, rv, ev);
    `CHK(ev, 1'b1);
    apb(1'b0, 16'h0830, 32'h0, rv, ev);
    `CHK({rv, ev}, 1'b1);
    // Live bits follow hardware, writes leave them alone
    for (int i = 0; i < 8; i++) begin
      {coreIn.linkUp, spll, cpll} <= 3'(i);
      repeat (4) @(posedge clk);
      rd(A_STAT, stat());
      wr(A_STAT, 32'hFF);
      rd(A_STAT, stat());
    end
    // Realignment flag sets and clears by writing one
    pulse(1'b0);
    rl = 1'b1;
    rd(A_STAT, stat());
    wr(A_STAT, 32'h10);
    rl = 1'b0;
    rd(A_STAT, stat());
    // Alignment flag: only the first SYSREF after enabling counts
    pulse(1'b1);
    rd(A_STAT, stat());
    for (int k = 0; k < 2; k++) begin
      ctrl = 32'h1;
      wr(A_CTRL, ctrl);
      `CHK(linkEnable, 1'b1);
      pulse(1'b1);
      al = 1'b1;
      rd(A_STAT, stat());
      wr(A_STAT, 32'h08);
      al = 1'b0;
      pulse(1'b1);
      rd(A_STAT, stat());
      ctrl = 32'h0;
      wr(A_CTRL, ctrl);
    end
    // Every sync source; pin and software at both levels, timestamp high only, receiver slow to release
    for (int i = 0; i < 8; i++) begin
      ctrl = {27'h0, i[0], i[2:1], 2'b00};
      wr(A_CTRL, ctrl);
      rv = rnd();
      tmstpPinN <= rv[0];
      reqSync <= rv[1];
      repeat (12) @(posedge clk);
      `CHK(syncReqN, (stat() >> 5) & 32'h1);
      rd(A_STAT, stat());
    end
    // Comma path over all codes, modes and enable states
    for (int s = 0; s < 8; s++) begin
      ctrl = 32'h0;
      wr(A_CTRL, ctrl);
      wr(A_EOF, {30'h0, s[1:0]});
      rd(A_EOF, {30'h0, s[1:0]});
      ctrl = {31'h0, s[2]};
      wr(A_CTRL, ctrl);
      for (int k = 0; k < 8; k++) begin
        @(posedge clk);
        rv = rnd();
        txIn <= rv[9:0];
        mode8b10b <= rv[10] | rv[11];
        @(posedge clk);
        #1;
        expTx = {rv[9:2], 1'b0};
        if (s[2] && (rv[10] | rv[11]) && rv[1] && rv[0] && s[1:0] != 2'h3)
          expTx = {(s[1:0] == 2'h0) ? SLF_K28_7 : (s[0] ? SLF_K28_1 : SLF_K28_5), 1'b1};
        `CHK(txOut, expTx);
      end
    end
    report_and_stop();
  end
endmodule : test_serial_link_frame_char_and_status
